// ==== src/icss_pkg.sv ====
// package: constants, types and contract list for the init/calibration status sequencer
// Contract
// - digest error sets sticky tamper flag
// - calib done only when selected banks done, or after timeout when the rest are unpowered or approximate
// - calib done independent of init done
// - unpowered selected bank holds done until timeout
// - late-powered bank gets approximate calibration
// - avionics flag low unless mode configured
// - avionics flag at later of both
// - bank readiness shown per bank supply
// - either warm reset starts initialization
// - memory init runs alongside calibration
package icss_pkg;
   localparam int          ICSS_NBANKS      = 4;
   localparam real         ICSS_CLK_MHZ     = 200.0;
   // ------------------------------------------------------------
   // timing, in microseconds, then in cycles
   // ------------------------------------------------------------
   localparam real         ICSS_TIMEOUT_US  = 100.0;
   localparam int          ICSS_TIMEOUT_CYC = int'(ICSS_TIMEOUT_US * ICSS_CLK_MHZ);
   localparam real         ICSS_INIT_US     = 50.0;
   localparam int          ICSS_INIT_CYC    = int'(ICSS_INIT_US * ICSS_CLK_MHZ);
   localparam int          ICSS_CAL_CYC     = 64;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0]  ICSS_A_STATUS    = 8'h00;
   localparam logic [7:0]  ICSS_A_CTRL      = 8'h04;
   localparam logic [7:0]  ICSS_A_IRQ_STAT  = 8'h08;
   localparam logic [7:0]  ICSS_A_IRQ_MASK  = 8'h0c;
   localparam logic [31:0] ICSS_CTRL_RST    = 32'h0000_000f;
   localparam int          ICSS_CTRL_AVM    = 0;
   localparam int          ICSS_CTRL_SEL    = 4;
   localparam int          ICSS_IRQ_INIT    = 0;
   localparam int          ICSS_IRQ_CAL     = 1;
   localparam int          ICSS_IRQ_TAMP    = 2;
   localparam int          ICSS_IRQ_TMO     = 3;
   localparam int          ICSS_NIRQ        = 4;

   typedef enum logic [1:0] {ICSS_INIT, ICSS_RUN, ICSS_DONE} icss_init_st_t;
   typedef enum logic [1:0] {ICSS_WAIT, ICSS_CAL, ICSS_OK} icss_bank_st_t;

   typedef struct packed {
      logic       init_done;
      logic       cal_done;
      logic       avm_flag;
      logic       tamper;
   } icss_flags_t;
endpackage : icss_pkg

// ==== src/icss_top.sv ====
// top: init/calibration status sequencer with AHB-Lite register slave
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
module icss_top
   import icss_pkg::*;
#(
   parameter int NBANKS      = ICSS_NBANKS,
   parameter int TIMEOUT_CYC = ICSS_TIMEOUT_CYC,
   parameter int INIT_CYC    = ICSS_INIT_CYC,
   parameter int CAL_CYC     = ICSS_CAL_CYC
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic              external_device_reset_n,
   input  wire logic              security_event_reset,
   input  wire logic [NBANKS-1:0] bank_io_supply,
   input  wire logic              recalibrate_request,
   input  wire logic              digest_error,
   output logic                   initialization_complete,
   output logic                   io_calibration_complete,
   output logic                   avionics_operation_flag,
   output logic      [NBANKS-1:0] bank_supply_good,
   output logic                   digest_tamper_flag,
   output logic      [NBANKS-1:0] bank_calib_approx,
   output logic                   irq
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      icss_init_st_t             ist;
      logic [31:0]               icnt;
      logic [31:0]               tcnt;
      logic                      tmo;
      icss_bank_st_t [NBANKS-1:0] bst;
      logic [NBANKS-1:0][15:0]   bcnt;
      logic [NBANKS-1:0]         approx;
      logic [NBANKS-1:0]         sup;
      icss_flags_t               fl;
      logic [31:0]               ctrl;
      logic [ICSS_NIRQ-1:0]      ist_sticky;
      logic [ICSS_NIRQ-1:0]      imask;
      logic                      dp_wr;
      logic                      dp_rd;
      logic [7:0]                dp_addr;
      logic [31:0]               rdata;
      logic                      init_d;
      logic                      cal_d;
      logic                      tmo_d;
   } icss_state_t;

   icss_state_t s_r, s_nxt;
   logic        warm;
   logic        addr_ok;
   logic [NBANKS-1:0] sel;
   logic        all_sel_ok;
   logic [ICSS_NIRQ-1:0] ev;

   assign warm = !external_device_reset_n || security_event_reset;
   assign sel  = s_r.ctrl[ICSS_CTRL_SEL +: NBANKS];
   assign addr_ok = hsel && htrans[1] && hready;

   always_comb begin
      s_nxt = s_r;
      all_sel_ok = 1'b1;
      ev = '0;
      s_nxt.sup = bank_io_supply;
      // --------------------------------------------------------
      // fabric/memory/transceiver init, concurrent with calibration
      // --------------------------------------------------------
      case (s_r.ist)
         ICSS_INIT: begin
            s_nxt.icnt = '0;
            s_nxt.ist  = ICSS_RUN;
         end
         ICSS_RUN: begin
            s_nxt.icnt = s_r.icnt + 32'd1;
            if (s_r.icnt >= 32'(INIT_CYC - 1)) begin
               s_nxt.ist          = ICSS_DONE;
               s_nxt.fl.init_done = 1'b1;
            end
         end
         ICSS_DONE: s_nxt.fl.init_done = 1'b1;
         default: s_nxt.ist = ICSS_INIT;
      endcase
      // --------------------------------------------------------
      // calibration timeout window
      // --------------------------------------------------------
      if (!s_r.tmo) begin
         s_nxt.tcnt = s_r.tcnt + 32'd1;
         if (s_r.tcnt >= 32'(TIMEOUT_CYC - 1))
            s_nxt.tmo = 1'b1;
      end
      // --------------------------------------------------------
      // per-bank calibration
      // --------------------------------------------------------
      for (int b = 0; b < NBANKS; b++) begin
         case (s_r.bst[b])
            ICSS_WAIT: begin
               s_nxt.bcnt[b] = '0;
               if (s_r.sup[b]) begin
                  s_nxt.bst[b]    = ICSS_CAL;
                  s_nxt.approx[b] = s_r.tmo;
               end
            end
            ICSS_CAL: begin
               s_nxt.bcnt[b] = s_r.bcnt[b] + 16'd1;
               if (s_r.bcnt[b] >= 16'(CAL_CYC - 1))
                  s_nxt.bst[b] = ICSS_OK;
               // a request mid-calibration restarts the bank so the rough trim is not kept
               if (recalibrate_request && s_r.sup[b]) begin
                  s_nxt.bst[b]    = ICSS_CAL;
                  s_nxt.bcnt[b]   = '0;
                  s_nxt.approx[b] = 1'b0;
               end
            end
            ICSS_OK: begin
               // accurate recalibration only on fabric request
               if (recalibrate_request && s_r.sup[b]) begin
                  s_nxt.bst[b]    = ICSS_CAL;
                  s_nxt.approx[b] = 1'b0;
               end
            end
            default: s_nxt.bst[b] = ICSS_WAIT;
         endcase
         if (!s_r.sup[b] && s_r.bst[b] != ICSS_WAIT)
            s_nxt.bst[b] = ICSS_WAIT;
         if (sel[b] && s_r.bst[b] != ICSS_OK && !s_r.tmo)
            all_sel_ok = 1'b0;
         if (sel[b] && s_r.bst[b] != ICSS_OK && s_r.tmo && !s_r.approx[b] && s_r.sup[b])
            all_sel_ok = 1'b0;
      end
      // independent of init_done; sticky until reset
      if (all_sel_ok)
         s_nxt.fl.cal_done = s_r.fl.cal_done || all_sel_ok;
      s_nxt.fl.avm_flag = s_r.ctrl[ICSS_CTRL_AVM] && s_r.fl.init_done && s_r.fl.cal_done;
      if (digest_error)
         s_nxt.fl.tamper = 1'b1;
      // --------------------------------------------------------
      // events and interrupt status
      // --------------------------------------------------------
      s_nxt.init_d = s_r.fl.init_done;
      s_nxt.cal_d  = s_r.fl.cal_done;
      s_nxt.tmo_d  = s_r.tmo;
      ev[ICSS_IRQ_INIT] = s_r.fl.init_done && !s_r.init_d;
      ev[ICSS_IRQ_CAL]  = s_r.fl.cal_done && !s_r.cal_d;
      ev[ICSS_IRQ_TAMP] = digest_error;
      ev[ICSS_IRQ_TMO]  = s_r.tmo && !s_r.tmo_d;
      // --------------------------------------------------------
      // AHB-Lite data phase, zero wait states
      // --------------------------------------------------------
      if (s_r.dp_wr) begin
         case (s_r.dp_addr)
            ICSS_A_CTRL:     s_nxt.ctrl = hwdata;
            ICSS_A_IRQ_STAT: s_nxt.ist_sticky = s_r.ist_sticky & ~hwdata[ICSS_NIRQ-1:0];
            ICSS_A_IRQ_MASK: s_nxt.imask = hwdata[ICSS_NIRQ-1:0];
            default: ;
         endcase
      end
      // set wins over a clear in the same cycle
      s_nxt.ist_sticky = s_nxt.ist_sticky | ev;
      s_nxt.dp_wr = addr_ok && hwrite;
      s_nxt.dp_rd = addr_ok && !hwrite;
      if (addr_ok)
         s_nxt.dp_addr = {haddr[7:2], 2'b00};
      s_nxt.rdata = '0;
      if (addr_ok && !hwrite) begin
         case ({haddr[7:2], 2'b00})
            ICSS_A_STATUS:   s_nxt.rdata = 32'({s_r.sup, s_r.fl.tamper, s_r.fl.avm_flag,
                                                s_r.fl.cal_done, s_r.fl.init_done});
            ICSS_A_CTRL:     s_nxt.rdata = s_r.ctrl;
            ICSS_A_IRQ_STAT: s_nxt.rdata = 32'(s_r.ist_sticky);
            ICSS_A_IRQ_MASK: s_nxt.rdata = 32'(s_r.imask);
            default:         s_nxt.rdata = '0;
         endcase
      end
      // warm reset restarts init and calibration; config is kept
      if (warm) begin
         s_nxt.ist  = ICSS_INIT;
         s_nxt.tcnt = '0;
         s_nxt.tmo  = 1'b0;
         s_nxt.fl.init_done = 1'b0;
         s_nxt.fl.cal_done  = 1'b0;
         s_nxt.fl.avm_flag  = 1'b0;
         for (int b = 0; b < NBANKS; b++)
            s_nxt.bst[b] = ICSS_WAIT;
         s_nxt.approx = '0;
         s_nxt.init_d = 1'b0;
         s_nxt.cal_d  = 1'b0;
         s_nxt.tmo_d  = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r      <= '0;
         s_r.ctrl <= ICSS_CTRL_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hrdata    = s_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign initialization_complete = s_r.fl.init_done;
   assign io_calibration_complete = s_r.fl.cal_done;
   assign avionics_operation_flag = s_r.fl.avm_flag;
   assign digest_tamper_flag      = s_r.fl.tamper;
   assign bank_supply_good        = s_r.sup;
   assign bank_calib_approx       = s_r.approx;
   assign irq = |(s_r.ist_sticky & s_r.imask);

   // ------------------------------------------------------------
   // assertion helpers
   // ------------------------------------------------------------
   logic [NBANKS-1:0] bank_ok;
   logic [NBANKS-1:0] bank_wait;

   generate
      for (genvar g = 0; g < NBANKS; g++) begin : g_bank_view
         assign bank_ok[g]   = (s_r.bst[g] == ICSS_OK);
         assign bank_wait[g] = (s_r.bst[g] == ICSS_WAIT);
      end
   endgenerate

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence warm_seen;
      !external_device_reset_n || security_event_reset;
   endsequence

   sequence warm_release;
      warm ##1 !warm;
   endsequence

   a_tamper_set: assert property (@(posedge hclk) disable iff (!hresetn)
      digest_error |=> digest_tamper_flag) else $error("tamper flag not set");
   a_tamper_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      digest_tamper_flag |=> digest_tamper_flag) else $error("tamper flag dropped");
   a_avm_off: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_r.ctrl[ICSS_CTRL_AVM] |=> !avionics_operation_flag) else $error("avionics flag without mode");
   a_avm_both: assert property (@(posedge hclk) disable iff (!hresetn)
      avionics_operation_flag |-> initialization_complete && io_calibration_complete)
      else $error("avionics flag early");
   a_warm_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      warm_seen |=> !initialization_complete && !io_calibration_complete && !avionics_operation_flag)
      else $error("flags survive warm reset");
   a_init_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      initialization_complete && !warm |=> initialization_complete) else $error("init flag dropped");
   a_cal_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(io_calibration_complete) |-> $past(s_r.tmo) || $past((sel & ~bank_ok) == '0))
      else $error("calib done early");
   a_supply_track: assert property (@(posedge hclk) disable iff (!hresetn)
      bank_supply_good == $past(bank_io_supply)) else $error("bank supply status wrong");
   a_cal_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      io_calibration_complete && !warm |=> io_calibration_complete) else $error("calib flag dropped");
   a_avm_follow: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.ctrl[ICSS_CTRL_AVM] && initialization_complete && io_calibration_complete && !warm
      |=> avionics_operation_flag) else $error("avionics flag missing");
   a_warm_restart: assert property (@(posedge hclk) disable iff (!hresetn)
      warm_release |=> !initialization_complete && !avionics_operation_flag)
      else $error("flags set right after warm reset");

   // ------------------------------------------------------------
   // calibration timeout and init counters
   // ------------------------------------------------------------
   a_tmo_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.tmo && !warm |=> s_r.tmo) else $error("timeout dropped");
   a_tmo_early: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_r.tmo && !warm && s_r.tcnt < 32'(TIMEOUT_CYC - 1) |=> !s_r.tmo)
      else $error("timeout too early");
   a_tmo_end: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_r.tmo && !warm && s_r.tcnt >= 32'(TIMEOUT_CYC - 1) |=> s_r.tmo)
      else $error("timeout missed");
   a_warm_tmo: assert property (@(posedge hclk) disable iff (!hresetn)
      warm_seen |=> !s_r.tmo) else $error("timeout survives warm reset");
   a_init_from_run: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(initialization_complete) |-> $past(s_r.ist == ICSS_RUN))
      else $error("init done without run");
   a_init_early: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.ist == ICSS_RUN && !warm && s_r.icnt < 32'(INIT_CYC - 1) |=> !initialization_complete)
      else $error("init done too early");
   a_init_end: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.ist == ICSS_RUN && !warm && s_r.icnt >= 32'(INIT_CYC - 1) |=> initialization_complete)
      else $error("init done missed");

   // ------------------------------------------------------------
   // approximate and accurate calibration
   // ------------------------------------------------------------
   a_approx_late: assert property (@(posedge hclk) disable iff (!hresetn)
      |(bank_calib_approx & ~$past(bank_calib_approx)) |-> $past(s_r.tmo))
      else $error("approx calibration before timeout");
   a_recal_accurate: assert property (@(posedge hclk) disable iff (!hresetn)
      recalibrate_request && !warm |=> (bank_calib_approx & $past(s_r.sup & ~bank_wait)) == '0)
      else $error("recalibration left rough trim");

   // one set of checks per bank; a dropped supply always wins over calibration
   generate
      for (genvar g = 0; g < NBANKS; g++) begin : g_bank_chk
         a_bank_drop: assert property (@(posedge hclk) disable iff (!hresetn)
            !bank_supply_good[g] && !bank_wait[g] |=> bank_wait[g])
            else $error("unpowered bank kept its state");
         a_bank_cal_len: assert property (@(posedge hclk) disable iff (!hresetn)
            $rose(bank_ok[g]) |-> $past(s_r.bcnt[g]) >= 16'(CAL_CYC - 1))
            else $error("bank calibration too short");
         a_bank_start: assert property (@(posedge hclk) disable iff (!hresetn)
            bank_wait[g] && bank_supply_good[g] && !warm |=> !bank_wait[g])
            else $error("powered bank not calibrated");
      end
   endgenerate

   // ------------------------------------------------------------
   // register slave and interrupt
   // ------------------------------------------------------------
   a_tamper_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      digest_error |=> s_r.ist_sticky[ICSS_IRQ_TAMP]) else $error("tamper event lost");
   a_rdata_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_r.dp_rd |-> hrdata == '0) else $error("read data outside a read");
   a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.dp_wr && s_r.dp_addr == ICSS_A_CTRL |=> s_r.ctrl == $past(hwdata))
      else $error("control write lost");
   a_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.dp_wr && s_r.dp_addr == ICSS_A_IRQ_MASK |=> s_r.imask == $past(hwdata[ICSS_NIRQ-1:0]))
      else $error("mask write lost");
   a_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
      s_r.imask == '0 |-> !irq) else $error("irq with all sources masked");
   a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      hresp == 1'b0) else $error("error response");
   a_zero_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout) else $error("wait state inserted");
endmodule : icss_top

// ==== bench/icss_fabric_model.sv ====
// fabric-side user logic: recalibration requester and readiness tracker
module icss_fabric_model
   import icss_pkg::*;
#(
   parameter int NBANKS = ICSS_NBANKS
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              initialization_complete,
   input  wire logic              io_calibration_complete,
   input  wire logic [NBANKS-1:0] bank_calib_approx,
   output logic                   recalibrate_request,
   output logic                   fabric_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [NBANKS-1:0] approx_seen_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         approx_seen_r       <= '0;
         recalibrate_request <= 1'b0;
      end else begin
         approx_seen_r       <= bank_calib_approx;
         // a late bank only has a rough trim until a new calibration is asked for
         recalibrate_request <= |(bank_calib_approx & ~approx_seen_r);
      end
   end
   assign fabric_ready = initialization_complete & io_calibration_complete;
endmodule : icss_fabric_model

// ==== bench/init_calibration_status_sequencer_test.sv ====
// testbench: register access, warm resets, calibration timeout and tamper interrupt
module init_calibration_status_sequencer_test
   import icss_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // shortened counts so the run stays brief
   localparam int TMO = 50;
   localparam int INI = 20;
   localparam int CAL = 8;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, fabric_ready;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        external_device_reset_n, security_event_reset, recalibrate_request, digest_error;
   logic        initialization_complete, io_calibration_complete, avionics_operation_flag, digest_tamper_flag;
   logic [3:0]  bank_io_supply, bank_supply_good, bank_calib_approx;
   logic [9:0]  obs;
   int          err_total, compares, n, t;
   assign hready = hreadyout;
   assign obs = {bank_calib_approx, fabric_ready, irq, digest_tamper_flag, avionics_operation_flag,
                 io_calibration_complete, initialization_complete};
   icss_top #(.TIMEOUT_CYC(TMO), .INIT_CYC(INI), .CAL_CYC(CAL)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .external_device_reset_n(external_device_reset_n), .security_event_reset(security_event_reset),
      .bank_io_supply(bank_io_supply), .recalibrate_request(recalibrate_request), .digest_error(digest_error),
      .initialization_complete(initialization_complete), .io_calibration_complete(io_calibration_complete),
      .avionics_operation_flag(avionics_operation_flag), .bank_supply_good(bank_supply_good),
      .digest_tamper_flag(digest_tamper_flag), .bank_calib_approx(bank_calib_approx), .irq(irq));
   icss_fabric_model #(.NBANKS(4)) fabric (
      .hclk(hclk), .hresetn(hresetn), .initialization_complete(initialization_complete),
      .io_calibration_complete(io_calibration_complete), .bank_calib_approx(bank_calib_approx),
      .recalibrate_request(recalibrate_request), .fabric_ready(fabric_ready));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic final_report;
      if (err_total == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) begin
         err_total++;
         final_report();
      end
   endtask : wait_rdy
   // one single word transfer; read data is taken at the data-phase ready edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      check("hresp", hresp, '0);
   endtask : xfer
   // polls one observed bit a little after each edge so outputs have settled
   task automatic wait_bit(input int b, input int lim);
      n = 0;
      while (obs[b] !== 1'b1) begin
         @(posedge hclk);
         #1;
         n++;
         if (n > lim) begin
            err_total++;
            final_report();
         end
      end
   endtask : wait_bit
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      err_total++;
      final_report();
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      external_device_reset_n = 1'b1;
      security_event_reset = 1'b0;
      bank_io_supply = 4'h0;
      digest_error = 1'b0;
      err_total = 0;
      compares = 0;
      repeat (6) @(posedge hclk);
      check("flags in reset", obs, '0);
      hresetn <= 1'b1;
      xfer(ICSS_A_CTRL, 1'b0, '0);
      check("ctrl reset", rd, ICSS_CTRL_RST);
      xfer(ICSS_A_IRQ_MASK, 1'b0, '0);
      check("mask reset", rd, 32'h0000_0000);
      xfer(8'h40, 1'b1, 32'hffff_ffff);
      xfer(8'h40, 1'b0, '0);
      check("unmapped", rd, 32'h0000_0000);
      wait_bit(0, 200);
      @(posedge hclk);
      external_device_reset_n <= 1'b0;
      xfer(ICSS_A_CTRL, 1'b1, 32'h0000_0030);
      bank_io_supply <= 4'h1;
      repeat (3) @(posedge hclk);
      #1 check("pin warm reset", obs[2:0], '0);
      @(posedge hclk);
      external_device_reset_n <= 1'b1;
      wait_bit(0, INI + 10);
      t = n;
      check("cal before timeout", obs[1], 1'b0);
      wait_bit(1, TMO + 20);
      check("cal after timeout", (t + n) >= TMO, 1'b1);
      check("avm unused", obs[2], 1'b0);
      @(posedge hclk);
      bank_io_supply <= 4'h3;
      wait_bit(7, CAL + 10);
      check("approx bank", bank_calib_approx, 4'h2);
      check("supply good", bank_supply_good, 4'h3);
      check("cal sticky", obs[1], 1'b1);
      repeat (CAL + 4) @(posedge hclk);
      #1 check("recal accurate", bank_calib_approx, 4'h0);
      @(posedge hclk);
      security_event_reset <= 1'b1;
      xfer(ICSS_A_CTRL, 1'b1, 32'h0000_0031);
      repeat (2) @(posedge hclk);
      #1 check("tamper warm reset", obs[2:0], '0);
      @(posedge hclk);
      security_event_reset <= 1'b0;
      wait_bit(1, CAL + 10);
      check("cal before init", obs[2:0], 3'b010);
      wait_bit(2, INI + 10);
      check("avm at later", obs[5:0], 6'b10_0111);
      xfer(ICSS_A_STATUS, 1'b0, '0);
      check("status word", rd, 32'h0000_0037);
      xfer(ICSS_A_IRQ_MASK, 1'b1, 32'h0000_0004);
      @(posedge hclk);
      digest_error <= 1'b1;
      @(posedge hclk);
      digest_error <= 1'b0;
      wait_bit(4, 10);
      check("tamper flag", obs[3], 1'b1);
      xfer(ICSS_A_IRQ_STAT, 1'b0, '0);
      check("tamper event", rd[ICSS_IRQ_TAMP], 1'b1);
      xfer(ICSS_A_IRQ_MASK, 1'b1, 32'h0000_0000);
      @(posedge hclk);
      #1 check("irq masked", irq, 1'b0);
      xfer(ICSS_A_IRQ_MASK, 1'b1, 32'h0000_0004);
      @(posedge hclk);
      #1 check("irq unmasked", irq, 1'b1);
      xfer(ICSS_A_IRQ_STAT, 1'b1, 32'h0000_0004);
      @(posedge hclk);
      #1 check("irq cleared", obs[4:3], 2'b01);
      final_report();
   end
endmodule : init_calibration_status_sequencer_test
